// [design/sptm_duty_mem.sv]
// sixteen-entry duty data memory with registered read port
`timescale 1ns/1ns
`default_nettype none
module sptm_duty_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     wr_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
    input  wire logic [WIDTH-1:0]         wr_data_in,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
    output logic      [WIDTH-1:0]         rd_data_out,
    output logic      [DEPTH*WIDTH-1:0]   all_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // ============================================================
    // storage; all entries must clear on reset so flat view is kept in flops
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_ent
            always_ff @(posedge sys_clk_in)
            begin
                if (rst_in)
                    mem_r[g] <= '0;
                else if (wr_en_in && wr_idx_in == ($clog2(DEPTH))'(g))
                    mem_r[g] <= wr_data_in;
            end
            assign all_data_out[g*WIDTH +: WIDTH] = mem_r[g];
        end
    endgenerate

    // registered read data
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            rd_data_out <= '0;
        else
            rd_data_out <= mem_r[rd_idx_in];
    end
endmodule
`default_nettype wire

// [design/sptm_pkg.sv]
// constants and register map of the sixteen channel pulse width timer
// ============================================================
// Notes on behaviour
// - all sixteen outputs come from one shared counter, period split into sub-pulses
// - undivided clock gives carrier of clock/16 (625 kHz at 10 MHz)
// - duty 0 to 255/256 in 1/256 steps; full high needs port output
// - each output has polarity choice and enable between timer and port
// - prescale register reachable only while flash window enable is 0
// - select bits 7 and 6 with two prescale bits choose counter clock
// - smallest pulse step is one selected counter clock period
// - conversion period is 256 counter clock steps, then repeats
// - sixteen basic pulses per conversion period
// - select register bit 5 reads 1, writes ignored
// - select register bit 4 reads 0, writes ignored
// - index bits 3..0 pick duty register 0 to 15 in binary
// - enable 0 stops clock; select 0 system clock; select 1 divide 2..16
// - duty upper nibble is basic duty, lower nibble extra-step count
// - phase bit 0 data is high width, 1 data is low width
// - direction 0 input, 1 with enable 0 port output, 1 1 timer
package sptm_pkg;
    // ============================================================
    // register byte addresses
    localparam logic [7:0] SPTM_SEL_ADDR    = 8'h00;
    localparam logic [7:0] SPTM_DATA_ADDR   = 8'h04;
    localparam logic [7:0] SPTM_PHASE_ADDR  = 8'h08;
    localparam logic [7:0] SPTM_OUTEN_ADDR  = 8'h0C;
    localparam logic [7:0] SPTM_PERIPHERAL_CLOCK_SELECT_REG_ADDR   = 8'h10;
    localparam logic [7:0] SPTM_SERIAL_TIMER_CONTROL_REG_ADDR   = 8'h14;
    localparam logic [7:0] SPTM_PDIR_ADDR   = 8'h18;
    localparam logic [7:0] SPTM_PORTD_ADDR  = 8'h1C;
    localparam logic [7:0] SPTM_PIN_ADDR    = 8'h20;
    localparam logic [7:0] SPTM_COUNT_ADDR  = 8'h24;
    // ============================================================
    // field positions
    localparam int SPTM_CKE_BIT   = 7;
    localparam int SPTM_CKS_BIT   = 6;
    localparam int SPTM_FLSH_BIT  = 3;
    localparam int SPTM_PSB_BIT   = 1;
    localparam int SPTM_PSA_BIT   = 0;
    // ============================================================
    // reset values and fixed bits
    localparam logic [7:0] SPTM_SEL_FIXED   = 8'h20;
    localparam logic [7:0] SPTM_SEL_RW_MASK = 8'hCF;
    localparam logic [7:0] SPTM_BYTE_RST    = 8'h00;
    localparam logic [15:0] SPTM_WORD_RST   = 16'h0000;
    localparam logic [7:0] SPTM_COUNT_LAST  = 8'hFF;
endpackage

// [design/sptm_top.sv]
// sixteen channel pulse width timer with apb register slave
`timescale 1ns/1ns
`default_nettype none
module sptm_top #(
    parameter int CHANNELS = 16
) (
    input  wire logic                sys_clk_in,
    input  wire logic                rst_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    input  wire logic [CHANNELS-1:0] pin_in,
    output logic      [CHANNELS-1:0] pin_out,
    output logic      [CHANNELS-1:0] pin_oe_out
);
    // ============================================================
    // registers
    logic [7:0]          sel_r;
    logic [CHANNELS-1:0] phase_r;
    logic [CHANNELS-1:0] outen_r;
    logic [CHANNELS-1:0] pdir_r;
    logic [CHANNELS-1:0] portd_r;
    logic [1:0]          peripheral_clock_select_reg_r;
    logic                flsh_r;
    logic [7:0]          count_r;
    logic [3:0]          div_r;
    logic [CHANNELS-1:0] pin_s1_r;
    logic [CHANNELS-1:0] pin_s2_r;
    logic                rd_pend_r;
    logic [31:0]         rdata_nxt;

    // ============================================================
    // apb decode; answer in access phase, one wait cycle on data reads
    wire setup_acc  = psel_in && !penable_in;
    wire access     = psel_in && penable_in;
    wire is_data    = paddr_in == sptm_pkg::SPTM_DATA_ADDR;
    wire wr_stb     = access && pwrite_in && pready_out;
    wire hit_sel    = paddr_in == sptm_pkg::SPTM_SEL_ADDR;
    wire hit_phase  = paddr_in == sptm_pkg::SPTM_PHASE_ADDR;
    wire hit_outen  = paddr_in == sptm_pkg::SPTM_OUTEN_ADDR;
    wire hit_peripheral_clock_select_reg   = paddr_in == sptm_pkg::SPTM_PERIPHERAL_CLOCK_SELECT_REG_ADDR;
    wire hit_serial_timer_control_reg   = paddr_in == sptm_pkg::SPTM_SERIAL_TIMER_CONTROL_REG_ADDR;
    wire hit_pdir   = paddr_in == sptm_pkg::SPTM_PDIR_ADDR;
    wire hit_portd  = paddr_in == sptm_pkg::SPTM_PORTD_ADDR;
    wire hit_pin    = paddr_in == sptm_pkg::SPTM_PIN_ADDR;
    wire hit_count  = paddr_in == sptm_pkg::SPTM_COUNT_ADDR;
    wire peripheral_clock_select_reg_open  = !flsh_r;
    wire mapped     = hit_sel | is_data | hit_phase | hit_outen | hit_serial_timer_control_reg | hit_pdir
                      | hit_portd | hit_pin | hit_count | (hit_peripheral_clock_select_reg & peripheral_clock_select_reg_open);
    wire [3:0] idx  = sel_r[3:0];

    // ============================================================
    // duty data memory, addressed by the select register index
    logic [7:0]             duty_rd;
    logic [CHANNELS*8-1:0]  duty_all;
    sptm_duty_mem #(
        .DEPTH (CHANNELS),
        .WIDTH (8)
    ) u_mem (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .wr_en_in     (wr_stb && is_data),
        .wr_idx_in    (idx),
        .wr_data_in   (pwdata_in[7:0]),
        .rd_idx_in    (idx),
        .rd_data_out  (duty_rd),
        .all_data_out (duty_all)
    );

    // ============================================================
    // read mux; fixed select bits forced here
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hit_sel)
            rdata_nxt[7:0] = (sel_r & sptm_pkg::SPTM_SEL_RW_MASK)
                             | sptm_pkg::SPTM_SEL_FIXED;
        else if (is_data)
            rdata_nxt[7:0] = duty_rd;
        else if (hit_phase)
            rdata_nxt[CHANNELS-1:0] = phase_r;
        else if (hit_outen)
            rdata_nxt[CHANNELS-1:0] = outen_r;
        else if (hit_peripheral_clock_select_reg && peripheral_clock_select_reg_open)
            rdata_nxt[1:0] = peripheral_clock_select_reg_r;
        else if (hit_serial_timer_control_reg)
            rdata_nxt[sptm_pkg::SPTM_FLSH_BIT] = flsh_r;
        else if (hit_pdir)
            rdata_nxt[CHANNELS-1:0] = pdir_r;
        else if (hit_portd)
            rdata_nxt[CHANNELS-1:0] = portd_r;
        else if (hit_pin)
            rdata_nxt[CHANNELS-1:0] = pin_s2_r;
        else if (hit_count)
            rdata_nxt[7:0] = count_r;
    end

    // ============================================================
    // bus handshake: data reads wait one cycle for the memory register
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pready_out  <= 1'b0;
            rd_pend_r   <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
        else
        begin
            rd_pend_r   <= setup_acc && is_data && !pwrite_in;
            pready_out  <= (setup_acc && !(is_data && !pwrite_in)) || rd_pend_r;
            prdata_out  <= rdata_nxt;
            pslverr_out <= ((setup_acc && !(is_data && !pwrite_in)) || rd_pend_r) && !mapped;
        end
    end

    // ============================================================
    // control register writes
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            sel_r   <= sptm_pkg::SPTM_BYTE_RST;
            phase_r <= '0;
            outen_r <= '0;
            pdir_r  <= '0;
            portd_r <= '0;
            peripheral_clock_select_reg_r  <= 2'b00;
            flsh_r  <= 1'b0;
        end
        else if (wr_stb)
        begin
            if (hit_sel)
                sel_r <= pwdata_in[7:0] & sptm_pkg::SPTM_SEL_RW_MASK;
            if (hit_phase)
                phase_r <= pwdata_in[CHANNELS-1:0];
            if (hit_outen)
                outen_r <= pwdata_in[CHANNELS-1:0];
            if (hit_pdir)
                pdir_r <= pwdata_in[CHANNELS-1:0];
            if (hit_portd)
                portd_r <= pwdata_in[CHANNELS-1:0];
            if (hit_peripheral_clock_select_reg && peripheral_clock_select_reg_open)
                peripheral_clock_select_reg_r <= pwdata_in[1:0];
            if (hit_serial_timer_control_reg)
                flsh_r <= pwdata_in[sptm_pkg::SPTM_FLSH_BIT];
        end
    end

    // ============================================================
    // counter clock selection as one-cycle enable pulses
    wire cke     = sel_r[sptm_pkg::SPTM_CKE_BIT];
    wire cks     = sel_r[sptm_pkg::SPTM_CKS_BIT];
    logic tick;
    always_comb
    begin
        tick = 1'b0;
        if (!cke)
            tick = 1'b0;
        else if (!cks)
            tick = 1'b1;
        else
            case (peripheral_clock_select_reg_r)
                2'b00:   tick = div_r[0] == 1'b1;
                2'b01:   tick = div_r[1:0] == 2'h3;
                2'b10:   tick = div_r[2:0] == 3'h7;
                default: tick = div_r == 4'hF;
            endcase
    end

    // prescaler and shared time base; prescaler runs only while enabled
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            div_r   <= 4'h0;
            count_r <= sptm_pkg::SPTM_BYTE_RST;
        end
        else
        begin
            div_r <= cke ? div_r + 4'h1 : 4'h0;
            if (tick)
                count_r <= count_r + 8'h01;
        end
    end

    // ============================================================
    // pulse division: low nibble of count is position inside basic
    // pulse, high nibble is which of the sixteen basic pulses
    function automatic logic wave_bit(input logic [7:0] duty, input logic [7:0] cnt);
        logic [4:0] width;
        width = {1'b0, duty[7:4]} + {4'h0, (cnt[7:4] < duty[3:0])};
        wave_bit = {1'b0, cnt[3:0]} < width;
    endfunction

    logic [CHANNELS-1:0] wave;
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_ch
            // phase bit turns data into low width by inversion
            assign wave[c] = wave_bit(duty_all[c*8 +: 8], count_r) ^ phase_r[c];
        end
    endgenerate

    // ============================================================
    // pin control, plus two-flop synchroniser for pin reads
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pin_out    <= '0;
            pin_oe_out <= '0;
            pin_s1_r   <= '0;
            pin_s2_r   <= '0;
        end
        else
        begin
            pin_oe_out <= pdir_r;
            pin_out    <= (outen_r & wave) | (~outen_r & portd_r);
            pin_s1_r   <= pin_in;
            pin_s2_r   <= pin_s1_r;
        end
    end
endmodule
`default_nettype wire

// [verification/sptm_bench.sv]
// self-checking bench for the pulse width timer
`timescale 1ns/1ns
`default_nettype none
module sptm_bench;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        psel = 1'b0;
    logic        pen  = 1'b0;
    logic        pwr  = 1'b0;
    logic [7:0]  pad  = 8'h00;
    logic [31:0] pwd  = 32'h00000000;
    logic [15:0] pins = 16'hA5C3;
    wire logic [31:0] prd;
    wire logic        prdy;
    wire logic        perr;
    wire logic [15:0] pout;
    wire logic [15:0] poe;
    logic [31:0] rd;
    logic        err;
    int          n_mismatch = 0;
    int          checked = 0;
    int          hi [16];
    // ============================================================
    // clock and design
    always #20 clk = ~clk;
    sptm_top #(.CHANNELS(16)) dut (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .pin_in(pins), .pin_out(pout), .pin_oe_out(poe));
    // ============================================================
    // tasks
    task automatic wrap_up();
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; the request stands until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk);
            if (prdy === 1'b1)
                break;
        end
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (i == 16)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    // high samples per channel over a whole number of periods
    task automatic measure(input int n);
        int k;
        int c;
        for (c = 0; c < 16; c++)
            hi[c] = 0;
        for (k = 0; k < n; k++)
        begin
            @(posedge clk);
            for (c = 0; c < 16; c++)
                hi[c] += int'(pout[c] === 1'b1);
        end
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        logic [31:0] c0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, sptm_pkg::SPTM_SEL_ADDR, 32'h0);
        check("select reset", rd, 32'h00000020);
        xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'h000000FF);
        xfer(1'b0, sptm_pkg::SPTM_SEL_ADDR, 32'h0);
        check("select bits", rd, 32'h000000EF);
        // every index: reset value, then a distinct duty value
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'(i));
            xfer(1'b0, sptm_pkg::SPTM_DATA_ADDR, 32'h0);
            check("duty reset", rd, 32'h0);
            xfer(1'b1, sptm_pkg::SPTM_DATA_ADDR, 32'(i * 17));
        end
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'(i));
            xfer(1'b0, sptm_pkg::SPTM_DATA_ADDR, 32'h0);
            check("duty read", rd, 32'(i * 17));
        end
        // prescale register locked while the flash window is open
        xfer(1'b1, sptm_pkg::SPTM_SERIAL_TIMER_CONTROL_REG_ADDR, 32'h00000008);
        xfer(1'b1, sptm_pkg::SPTM_PERIPHERAL_CLOCK_SELECT_REG_ADDR, 32'h00000003);
        check("locked error", {31'h0, err}, 32'h1);
        xfer(1'b1, sptm_pkg::SPTM_SERIAL_TIMER_CONTROL_REG_ADDR, 32'h0);
        xfer(1'b0, sptm_pkg::SPTM_PERIPHERAL_CLOCK_SELECT_REG_ADDR, 32'h0);
        check("prescale kept", rd, 32'h0);
        xfer(1'b0, 8'h28, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        // odd channels inverted, all on the undivided clock
        xfer(1'b1, sptm_pkg::SPTM_PDIR_ADDR, 32'h0000FFFF);
        xfer(1'b1, sptm_pkg::SPTM_PHASE_ADDR, 32'h0000AAAA);
        xfer(1'b1, sptm_pkg::SPTM_OUTEN_ADDR, 32'h0000FFFF);
        xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'h00000080);
        repeat (4) @(posedge clk);
        measure(256);
        for (int c = 0; c < 16; c++)
            check("high count", 32'(hi[c]), 32'((c % 2) ? 256 - c * 17 : c * 17));
        check("drive", {16'h0, poe}, 32'h0000FFFF);
        // each prescale step, after a stop that must freeze the counter
        for (int p = 0; p < 4; p++)
        begin
            xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'h0);
            xfer(1'b0, sptm_pkg::SPTM_COUNT_ADDR, 32'h0);
            c0 = rd;
            xfer(1'b0, sptm_pkg::SPTM_COUNT_ADDR, 32'h0);
            check("stopped count", rd, c0);
            xfer(1'b1, sptm_pkg::SPTM_PERIPHERAL_CLOCK_SELECT_REG_ADDR, 32'(p));
            xfer(1'b1, sptm_pkg::SPTM_SEL_ADDR, 32'h000000C0);
            repeat (40) @(posedge clk);
            measure(256 << (p + 1));
            check("divided count", 32'(hi[2]), 32'(34 << (p + 1)));
        end
        // plain port mode on the low half
        xfer(1'b1, sptm_pkg::SPTM_OUTEN_ADDR, 32'h0);
        xfer(1'b1, sptm_pkg::SPTM_PORTD_ADDR, 32'h00001234);
        xfer(1'b1, sptm_pkg::SPTM_PDIR_ADDR, 32'h000000FF);
        repeat (4) @(posedge clk);
        check("port out", {16'h0, pout}, 32'h00001234);
        check("port drive", {16'h0, poe}, 32'h000000FF);
        xfer(1'b0, sptm_pkg::SPTM_PIN_ADDR, 32'h0);
        check("pin read", rd, 32'h0000A5C3);
        wrap_up();
    end
endmodule
`default_nettype wire

// [verification/sptm_chk.sv]
// concurrent checks on the pulse width timer ports
`timescale 1ns/1ns
`default_nettype none
module sptm_chk #(
    parameter int CHANNELS = 16
) (
    input wire logic                sys_clk_in,
    input wire logic                rst_in,
    input wire logic                psel_in,
    input wire logic                penable_in,
    input wire logic                pwrite_in,
    input wire logic [7:0]          paddr_in,
    input wire logic [31:0]         pwdata_in,
    input wire logic [31:0]         prdata_out,
    input wire logic                pready_out,
    input wire logic                pslverr_out,
    input wire logic [CHANNELS-1:0] pin_in,
    input wire logic [CHANNELS-1:0] pin_out,
    input wire logic [CHANNELS-1:0] pin_oe_out
);
    // ============================================================
    // helpers
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // a completed direction write is the only cause of a new drive pattern
    logic dir_wr;
    assign dir_wr = pready_out && pwrite_in && !pslverr_out && paddr_in == sptm_pkg::SPTM_PDIR_ADDR;
    // ============================================================
    // bus answer shape
    property p_ready_pulse; pready_out |=> !pready_out; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
    property p_ready_access; pready_out |-> psel_in && penable_in; endproperty
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_answer_bound; psel_in && $rose(penable_in) |-> ##[0:1] pready_out; endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("answer too late");
    property p_upper_zero; pready_out && !pwrite_in |-> prdata_out[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    // ============================================================
    // register content
    property p_sel_fixed;
        pready_out && !pwrite_in && paddr_in == sptm_pkg::SPTM_SEL_ADDR |-> prdata_out[5:4] == 2'b10;
    endproperty
    a_sel_fixed: assert property (p_sel_fixed) else $error("select fixed bits wrong");
    property p_unmapped;
        pready_out && paddr_in > sptm_pkg::SPTM_COUNT_ADDR |-> pslverr_out && prdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_oe_cause; $changed(pin_oe_out) |-> $past(dir_wr, 1) || $past(dir_wr, 2); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("drive changed on its own");
endmodule
bind sptm_top sptm_chk #(.CHANNELS(CHANNELS)) u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out));
`default_nettype wire
